// file: hdl/led_effect_params.svh
// Offsets, field positions, reset values and timing counts of the touch effect block
// Operation
// - Each time step count adds 20 ms
// - Ramp select bits 7:6 pick time 1-4
// - Bits 5:3 pick target brightness, 100 to 0
// - Bits 2:0 pick replays after release
// - Each effect A register drives its output group; outputs 4-6 effect B is stored and read back only
// - Effects disabled ignores effect registers entirely
`ifndef LED_EFFECT_PARAMS_SVH
`define LED_EFFECT_PARAMS_SVH

`define OFS_EFFECT_TIME_SECOND      8'h03
`define OFS_EFFECT_TIME_THIRD       8'h04
`define OFS_EFFECT_TIME_FOURTH      8'h05
`define OFS_OUTPUT0_EFFECT_A        8'h06
`define OFS_OUTPUTS123_EFFECT_A     8'h08
`define OFS_OUTPUTS456_EFFECT_A     8'h0A
`define OFS_OUTPUTS456_EFFECT_B     8'h0B
`define OFS_OUTPUTS789_EFFECT_A     8'h0C

`define RST_REG                     8'h00

`define FLD_RAMP_SEL_HI             7
`define FLD_RAMP_SEL_LO             6
`define FLD_UPPER_HI                5
`define FLD_UPPER_LO                3
`define FLD_REPLAY_HI               2
`define FLD_REPLAY_LO               0

`define EFFECT_STEP_MS              20
`define CLK_SYS_MHZ                 200
`define EFFECT_STEP_CYCLES          (`EFFECT_STEP_MS * 1000 * `CLK_SYS_MHZ)
`define PERCENT_STEPS               100
`define SUBSTEP_CYCLES              (`EFFECT_STEP_CYCLES / `PERCENT_STEPS)

`endif

// file: hdl/led_effect_pkg.sv
// Types shared by the touch effect block
`default_nettype none
package led_effect_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RAMP = 2'b01,
    PH_HOLD = 2'b10
  } phase_e;

  typedef logic [6:0] level_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] time_second;
    logic [7:0] time_third;
    logic [7:0] time_fourth;
    logic [3:0][7:0] effect_a;
    logic [7:0] outputs456_b;
  } regs_s;

endpackage : led_effect_pkg
`default_nettype wire

// file: hdl/led_effect_timing_intensity.sv
// Touch LED effect sequencer: registers, ramps, replays and PWM on ten outputs
`default_nettype none
`include "led_effect_params.svh"

module led_effect_timing_intensity
  import led_effect_pkg::*;
#(
  parameter int SUBSTEP_CYCLES = `SUBSTEP_CYCLES
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  input  wire reg_req_s   REG_REQ,
  output var  logic [7:0] REG_RD_DATA,
  input  wire logic       TOUCH_EFFECT_EN,
  input  wire logic [9:0] BUTTON_TOUCH,
  input  wire logic [7:0] EFFECT_TIME_FIRST,
  output var  logic [9:0] DRIVEN_OUTPUT_N
);

  localparam level_t FULL = 7'(`PERCENT_STEPS);

  // Sub-step counter is only 16 bits wide
  if (SUBSTEP_CYCLES < 1 || SUBSTEP_CYCLES > 65535) begin : g_bad_substep
    $error("SUBSTEP_CYCLES out of range");
  end

  typedef struct packed {
    regs_s                regs;
    logic [9:0][1:0]      phase;
    logic [9:0][6:0]      level;
    logic [9:0][15:0]     acc;
    logic [9:0][6:0]      span;
    logic [9:0][2:0]      replays;
    logic [9:0]           touch_prev;
    logic [15:0]          sub_cnt;
    logic [6:0]           pwm_cnt;
    logic [9:0]           out_n;
    logic [7:0]           rd_data;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Output index to its effect register
  function automatic logic [1:0] group_of(input int idx);
    if (idx == 0)     group_of = 2'd0;
    else if (idx < 4) group_of = 2'd1;
    else if (idx < 7) group_of = 2'd2;
    else              group_of = 2'd3;
  endfunction : group_of

  function automatic level_t upper_pct(input logic [2:0] code);
    case (code)
      3'b000:  upper_pct = 7'd100;
      3'b001:  upper_pct = 7'd90;
      3'b010:  upper_pct = 7'd80;
      3'b011:  upper_pct = 7'd65;
      3'b100:  upper_pct = 7'd50;
      3'b101:  upper_pct = 7'd40;
      3'b110:  upper_pct = 7'd20;
      default: upper_pct = 7'd0;
    endcase
  endfunction : upper_pct

  // Undefined codes give no replay
  function automatic logic [2:0] replay_count(input logic [2:0] code);
    case (code)
      3'b000:  replay_count = 3'd0;
      3'b001:  replay_count = 3'd1;
      3'b010:  replay_count = 3'd2;
      3'b011:  replay_count = 3'd4;
      3'b100:  replay_count = 3'd6;
      default: replay_count = 3'd0;
    endcase
  endfunction : replay_count

  always_comb begin
    logic [7:0]  cfg;
    logic [7:0]  dur;
    logic [15:0] dur_sub;
    level_t      tgt;
    level_t      delta;
    logic [15:0] acc_sum;
    logic        sub_tick;
    logic        rise;
    logic        fall;
    level_t      step;
    cfg      = 8'h00;
    dur      = 8'h00;
    dur_sub  = 16'h0000;
    tgt      = 7'd0;
    delta    = 7'd0;
    acc_sum  = 16'h0000;
    rise     = 1'b0;
    fall     = 1'b0;
    step     = 7'd0;
    s_nxt    = s_r;
    sub_tick = (s_r.sub_cnt == 16'(SUBSTEP_CYCLES - 1));
    s_nxt.sub_cnt = sub_tick ? 16'h0000 : s_r.sub_cnt + 16'h0001;
    // PWM frame of one hundred clocks, one clock per percent
    s_nxt.pwm_cnt = (s_r.pwm_cnt == FULL - 7'd1) ? 7'd0 : s_r.pwm_cnt + 7'd1;

    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        `OFS_EFFECT_TIME_SECOND:  s_nxt.regs.time_second  = REG_REQ.wdata;
        `OFS_EFFECT_TIME_THIRD:   s_nxt.regs.time_third   = REG_REQ.wdata;
        `OFS_EFFECT_TIME_FOURTH:  s_nxt.regs.time_fourth  = REG_REQ.wdata;
        `OFS_OUTPUT0_EFFECT_A:    s_nxt.regs.effect_a[0]  = REG_REQ.wdata;
        `OFS_OUTPUTS123_EFFECT_A: s_nxt.regs.effect_a[1]  = REG_REQ.wdata;
        `OFS_OUTPUTS456_EFFECT_A: s_nxt.regs.effect_a[2]  = REG_REQ.wdata;
        `OFS_OUTPUTS456_EFFECT_B: s_nxt.regs.outputs456_b = REG_REQ.wdata;
        `OFS_OUTPUTS789_EFFECT_A: s_nxt.regs.effect_a[3]  = REG_REQ.wdata;
        default: ;
      endcase
    end
    case (REG_REQ.addr)
      `OFS_EFFECT_TIME_SECOND:  s_nxt.rd_data = s_r.regs.time_second;
      `OFS_EFFECT_TIME_THIRD:   s_nxt.rd_data = s_r.regs.time_third;
      `OFS_EFFECT_TIME_FOURTH:  s_nxt.rd_data = s_r.regs.time_fourth;
      `OFS_OUTPUT0_EFFECT_A:    s_nxt.rd_data = s_r.regs.effect_a[0];
      `OFS_OUTPUTS123_EFFECT_A: s_nxt.rd_data = s_r.regs.effect_a[1];
      `OFS_OUTPUTS456_EFFECT_A: s_nxt.rd_data = s_r.regs.effect_a[2];
      `OFS_OUTPUTS456_EFFECT_B: s_nxt.rd_data = s_r.regs.outputs456_b;
      `OFS_OUTPUTS789_EFFECT_A: s_nxt.rd_data = s_r.regs.effect_a[3];
      default:                  s_nxt.rd_data = 8'h00;
    endcase

    s_nxt.touch_prev = BUTTON_TOUCH;
    for (int i = 0; i < 10; i++) begin
      cfg  = s_r.regs.effect_a[group_of(i)];
      case (cfg[`FLD_RAMP_SEL_HI:`FLD_RAMP_SEL_LO])
        2'b00:   dur = EFFECT_TIME_FIRST;
        2'b01:   dur = s_r.regs.time_second;
        2'b10:   dur = s_r.regs.time_third;
        default: dur = s_r.regs.time_fourth;
      endcase
      // Duration in sub-steps: one step is 20 ms, split into 100 parts
      dur_sub = 16'(dur) * 16'(`PERCENT_STEPS);
      tgt   = upper_pct(cfg[`FLD_UPPER_HI:`FLD_UPPER_LO]);
      delta = (tgt > s_r.level[i]) ? tgt - s_r.level[i] : s_r.level[i] - tgt;
      // Span is fixed at ramp start; a shrinking distance would give an exponential fade
      step    = (s_r.span[i] == 7'd0) ? 7'd1 : s_r.span[i];
      acc_sum = s_r.acc[i] + 16'(step);
      rise  = BUTTON_TOUCH[i] & ~s_r.touch_prev[i];
      fall  = ~BUTTON_TOUCH[i] & s_r.touch_prev[i];

      if (!TOUCH_EFFECT_EN) begin
        // Plain on/off follow; effect settings carry no weight here
        s_nxt.level[i]   = BUTTON_TOUCH[i] ? FULL : 7'd0;
        s_nxt.phase[i]   = PH_IDLE;
        s_nxt.acc[i]     = 16'h0000;
        s_nxt.replays[i] = 3'd0;
      end else if (rise) begin
        s_nxt.phase[i]   = PH_RAMP;
        s_nxt.span[i]    = delta;
        s_nxt.acc[i]     = 16'h0000;
        s_nxt.replays[i] = 3'd0;
      end else if (fall) begin
        // Replays start from dark; a count of zero just turns off
        s_nxt.replays[i] = replay_count(cfg[`FLD_REPLAY_HI:`FLD_REPLAY_LO]);
        s_nxt.span[i]    = tgt;
        s_nxt.level[i]   = 7'd0;
        s_nxt.acc[i]     = 16'h0000;
        s_nxt.phase[i]   = (replay_count(cfg[`FLD_REPLAY_HI:`FLD_REPLAY_LO]) != 3'd0)
                           ? PH_RAMP : PH_IDLE;
      end else begin
        case (phase_e'(s_r.phase[i]))
          PH_RAMP: begin
            if (s_r.level[i] == tgt) begin
              if (BUTTON_TOUCH[i]) begin
                s_nxt.phase[i] = PH_HOLD;
              end else if (s_r.replays[i] > 3'd1) begin
                s_nxt.replays[i] = s_r.replays[i] - 3'd1;
                s_nxt.span[i]    = tgt;
                s_nxt.level[i]   = 7'd0;
                s_nxt.acc[i]     = 16'h0000;
              end else begin
                s_nxt.replays[i] = 3'd0;
                s_nxt.level[i]   = 7'd0;
                s_nxt.phase[i]   = PH_IDLE;
              end
            end else if (dur == 8'h00) begin
              s_nxt.level[i] = tgt;
            end else if (sub_tick) begin
              // Error accumulator spreads the percent steps evenly over the duration
              if (acc_sum >= dur_sub) begin
                s_nxt.acc[i]   = acc_sum - dur_sub;
                s_nxt.level[i] = (tgt > s_r.level[i]) ? s_r.level[i] + 7'd1
                                                      : s_r.level[i] - 7'd1;
              end else begin
                s_nxt.acc[i]   = acc_sum;
              end
            end
          end
          PH_HOLD: begin
            // Target change while held is followed at once
            s_nxt.level[i] = tgt;
          end
          PH_IDLE: ;
          default: s_nxt.phase[i] = PH_IDLE;
        endcase
      end
      s_nxt.out_n[i] = ~(s_r.pwm_cnt < s_r.level[i]);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_r                   <= '0;
      s_r.regs.time_second  <= `RST_REG;
      s_r.regs.time_third   <= `RST_REG;
      s_r.regs.time_fourth  <= `RST_REG;
      s_r.regs.effect_a     <= {4{`RST_REG}};
      s_r.regs.outputs456_b <= `RST_REG;
      s_r.out_n             <= 10'h3FF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RD_DATA     = s_r.rd_data;
  assign DRIVEN_OUTPUT_N = s_r.out_n;

endmodule : led_effect_timing_intensity
`default_nettype wire

// file: verification/led_array.sv
// LED array model: counts lit cycles on each active-low output
`default_nettype none
module led_array (
  input  wire logic       CLK_SYS,
  input  wire logic       CLEAR,
  input  wire logic [9:0] DRIVEN_OUTPUT_N,
  output var  int         LIT_CNT [10]
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge CLK_SYS)
    for (int i = 0; i < 10; i++) LIT_CNT[i] <= CLEAR ? 0 : LIT_CNT[i] + int'(!DRIVEN_OUTPUT_N[i]);
endmodule : led_array
`default_nettype wire

// file: verification/led_effect_sva.sv
// Port checker for the touch effect block
`default_nettype none
module led_effect_sva
  import led_effect_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       RESET,
  input wire reg_req_s   REG_REQ,
  input wire logic [7:0] REG_RD_DATA,
  input wire logic       TOUCH_EFFECT_EN,
  input wire logic [9:0] BUTTON_TOUCH,
  input wire logic [7:0] EFFECT_TIME_FIRST,
  input wire logic [9:0] DRIVEN_OUTPUT_N
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  wire logic is_map = REG_REQ.addr inside {8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0B, 8'h0C};
  logic [7:0] cfg0_r;
  always_ff @(posedge CLK_SYS) begin
    if (RESET) cfg0_r <= 8'h00;
    else if (REG_REQ.wr && REG_REQ.addr == 8'h06) cfg0_r <= REG_REQ.wdata;
  end
  sequence wr_then_rd;
    REG_REQ.wr && is_map ##1 !REG_REQ.wr && $stable(REG_REQ.addr);
  endsequence
  // Ramp select 00 with zero time reaches target in one cycle
  sequence touched_steady;
    (TOUCH_EFFECT_EN && BUTTON_TOUCH[0] && EFFECT_TIME_FIRST == 8'h00 && cfg0_r[7:6] == 2'b00
     && $stable(cfg0_r))[*4];
  endsequence
  chk_reg_readback: assert property (wr_then_rd |=> REG_RD_DATA == $past(REG_REQ.wdata, 2))
    else $error("readback differs");
  chk_unmapped_zero: assert property (!is_map |=> REG_RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  chk_disabled_on: assert property ((!TOUCH_EFFECT_EN && &BUTTON_TOUCH)[*3] |-> DRIVEN_OUTPUT_N == 10'h000)
    else $error("disabled touch not full on");
  chk_disabled_off: assert property ((!TOUCH_EFFECT_EN && BUTTON_TOUCH == 10'h000)[*3] |-> &DRIVEN_OUTPUT_N)
    else $error("disabled release not off");
  chk_full_target: assert property (touched_steady |-> cfg0_r[5:3] != 3'b000 || !DRIVEN_OUTPUT_N[0])
    else $error("full target not lit");
  chk_zero_target: assert property (touched_steady |-> cfg0_r[5:3] != 3'b111 || DRIVEN_OUTPUT_N[0])
    else $error("zero target lit");
  chk_release_dark: assert property ($fell(BUTTON_TOUCH[0]) && TOUCH_EFFECT_EN && cfg0_r[2:0] == 3'b000
    ##1 (!BUTTON_TOUCH[0] && TOUCH_EFFECT_EN)[*2] |-> DRIVEN_OUTPUT_N[0])
    else $error("lit after release without replay");
endmodule : led_effect_sva
bind led_effect_timing_intensity led_effect_sva chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .REG_REQ(REG_REQ), .REG_RD_DATA(REG_RD_DATA), .TOUCH_EFFECT_EN(TOUCH_EFFECT_EN),
  .BUTTON_TOUCH(BUTTON_TOUCH), .EFFECT_TIME_FIRST(EFFECT_TIME_FIRST),
  .DRIVEN_OUTPUT_N(DRIVEN_OUTPUT_N));
`default_nettype wire

// file: verification/led_effect_timing_intensity_bench.sv
// Self-checking bench for the touch effect block
`default_nettype none
module led_effect_timing_intensity_bench;
  import led_effect_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 0, rst = 1, en = 0, clr = 0;
  logic [9:0] btn = 0, drv_n;
  logic [7:0] rd_data, t1 = 8'h00;
  reg_req_s   req = '0;
  int         lit [10];
  int         mismatches = 0, num_checks = 0;
  logic [7:0] shadow [16] = '{default: 8'h00};
  always #2.5 clk = ~clk;
  led_effect_timing_intensity #(.SUBSTEP_CYCLES(4)) DUT (.CLK_SYS(clk), .RESET(rst),
    .REG_REQ(req), .REG_RD_DATA(rd_data), .TOUCH_EFFECT_EN(en), .BUTTON_TOUCH(btn),
    .EFFECT_TIME_FIRST(t1), .DRIVEN_OUTPUT_N(drv_n));
  led_array LEDS (.CLK_SYS(clk), .CLEAR(clr), .DRIVEN_OUTPUT_N(drv_n), .LIT_CNT(lit));
  function automatic int pct(input logic [2:0] c);
    int t[8] = '{100, 90, 80, 65, 50, 40, 20, 0};
    return t[c];
  endfunction : pct
  function automatic int reps(input logic [2:0] c);
    int t[5] = '{0, 1, 2, 4, 6};
    return t[c];
  endfunction : reps
  function automatic int grp(input int i);
    return i == 0 ? 0 : (i - 1) / 3 + 1;
  endfunction : grp
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1};
    @(posedge clk) req.wr <= 1'b0;
  endtask : reg_write
  task automatic reg_check(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0};
    repeat (2) @(posedge clk);
    #1 check(rd_data === d, "register read");
  endtask : reg_check
  // Lit-cycle count over n clocks; result sits in lit afterwards
  task automatic measure(input int n);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : measure
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    logic [7:0] a, d;
    int n;
    void'($urandom(86));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 16; k++) reg_check(8'(k), 8'h00);
    repeat (24) begin
      a = 8'($urandom_range(2, 13));
      d = 8'($urandom);
      reg_write(a, d);
      if (a inside {8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0B, 8'h0C}) shadow[a[3:0]] = d;
    end
    for (int k = 0; k < 16; k++) reg_check(8'(k), shadow[k]);
    $display("done registers");
    @(posedge clk) btn <= 10'h3ff;
    measure(100);
    for (int i = 0; i < 10; i++) check(lit[i] == 100, "disabled touch");
    @(posedge clk) btn <= 10'h000;
    measure(100);
    for (int i = 0; i < 10; i++) check(lit[i] == 0, "disabled release");
    $display("done disabled");
    @(posedge clk) en <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      for (int g = 0; g < 4; g++) reg_write(8'h06 + 8'(2 * g), {2'b00, 3'(c + g), 3'b000});
      @(posedge clk) btn <= 10'h3ff;
      repeat (5) @(posedge clk);
      measure(100);
      for (int i = 0; i < 10; i++) check(lit[i] == pct(3'(c + grp(i))), "intensity");
      @(posedge clk) btn <= 10'h000;
    end
    $display("done intensity");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) t1 <= 8'(s == 0);
      for (int r = 3; r < 6; r++) reg_write(8'(r), 8'(r == s + 2));
      reg_write(8'h06, {2'(s), 6'h00});
      @(posedge clk) btn <= 10'h001;
      repeat (60) @(posedge clk);
      measure(100);
      check(lit[0] > 5 && lit[0] < 95, "ramp midway");
      repeat (400) @(posedge clk);
      measure(100);
      check(lit[0] == 100, "ramp end");
      @(posedge clk) btn <= 10'h000;
    end
    $display("done ramp");
    reg_write(8'h03, 8'h01);
    for (int c = 0; c < 5; c++) begin
      reg_write(8'h06, {2'b01, 3'b000, 3'(c)});
      @(posedge clk) btn <= 10'h001;
      repeat (500) @(posedge clk);
      @(posedge clk) btn <= 10'h000;
      measure(3000);
      n = 200 * reps(3'(c));
      check(lit[0] >= n - 80 && lit[0] <= n + 80, "replays");
    end
    $display("done replay");
    stop_test;
  end
  initial begin
    #400000;
    mismatches++;
    stop_test;
  end
endmodule : led_effect_timing_intensity_bench
`default_nettype wire
